// file: hw/ids_pkg.sv
// Constants for the swap, test, exclusive-OR and DSP load decoder.
// Assumes a 16-bit instruction stream and a 32-bit data bus.
package ids_pkg;
   // Opcode match masks
   localparam logic [15:0] MASK_NM = 16'hf00f;
   localparam logic [15:0] MASK_N = 16'hf0ff;
   localparam logic [15:0] MASK_HI = 16'hff00;
   // Opcode match values
   localparam logic [15:0] OP_SWAPB = 16'h6008;
   localparam logic [15:0] OP_SWAPW = 16'h6009;
   localparam logic [15:0] OP_TSET = 16'h401b;
   localparam logic [15:0] OP_TRAP = 16'hc300;
   localparam logic [15:0] OP_ANDI_T = 16'hc800;
   localparam logic [15:0] OP_AND_T = 16'h2008;
   localparam logic [15:0] OP_ANDB_T = 16'hcc00;
   localparam logic [15:0] OP_XORI = 16'hca00;
   localparam logic [15:0] OP_XOR = 16'h200a;
   localparam logic [15:0] OP_XORB = 16'hce00;
   localparam logic [15:0] OP_MIDX = 16'h200d;
   localparam logic [15:0] OP_FIN_REL = 16'h8e00;
   localparam logic [15:0] OP_BEG_REL = 16'h8c00;
   localparam logic [15:0] OP_SETR = 16'h4014;
   localparam logic [15:0] OP_SETI = 16'h8200;
   localparam logic [3:0] OP_GRP4 = 4'h4;
   // DSP load targets; code is array index plus one
   localparam int CTL_N = 9;
   localparam logic [3:0] DST_NONE = 4'h0;
   localparam logic [3:0] DST_WRAP = 4'h1;
   localparam logic [3:0] DST_FIN = 4'h2;
   localparam logic [3:0] DST_BEG = 4'h3;
   localparam logic [3:0] DST_TSET = 4'ha;
   localparam logic [3:0] DST_ANDB = 4'hb;
   localparam logic [3:0] DST_XORB = 4'hc;
   localparam logic [3:0] DST_VEC = 4'hd;
   // Low bytes: wrap, finish, begin, flags, accum, x0, x1, y0, y1
   localparam logic [7:0] REG_LOW [CTL_N] = '{8'h5e, 8'h7e, 8'h6e, 8'h6a, 8'h7a, 8'h8a, 8'h9a, 8'haa, 8'hba};
   localparam logic [7:0] MEM_LOW [CTL_N] = '{8'h57, 8'h77, 8'h67, 8'h66, 8'h76, 8'h86, 8'h96, 8'ha6, 8'hb6};
   // Cycle counts
   localparam logic [3:0] CYC_ONE = 4'h1;
   localparam logic [3:0] CYC_TSET = 4'h4;
   localparam logic [3:0] CYC_TRAP = 4'h8;
   localparam logic [3:0] CYC_ANDB = 4'h3;
   localparam logic [3:0] CYC_XORB = 4'h3;
   localparam logic [3:0] CYC_LDCL = 4'h3;
   localparam logic [3:0] TRAP_STEP_PC = CYC_TRAP - CYC_ONE;
   localparam logic [3:0] TRAP_STEP_VEC = TRAP_STEP_PC - CYC_ONE;
   // Arithmetic and field constants
   localparam logic [31:0] WORD_STEP = 32'h4;
   localparam logic [31:0] PC_STEP = 32'h2;
   localparam logic [31:0] PC_READ_OFS = 32'h4;
   localparam logic [3:0] SP_IDX = 4'hf;
   localparam logic [3:0] IDX_ZERO = 4'h0;
   localparam logic [7:0] TSET_MSB = 8'h80;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int SR_T = 0;
   localparam int CNT_LO = 16;
   localparam int CNT_IMM_HI = 23;
   localparam int CNT_TOP_LO = 24;
   localparam int CNT_HI = 27;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STALL = 2'b01,
      ST_TRAP = 2'b10
   } ids_state_t;
endpackage

// file: hw/ids_core.sv
// Execute logic for swaps, test-and-set, trap, AND tests, XOR, extract and DSP loads.
// Assumes same-clock fetch and a data memory that answers a read in the cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module ids_core
   import ids_pkg::*;
#(
   parameter logic [31:0] PC_RESET = 32'h0,
   parameter logic [31:0] SR_RESET = 32'h0
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic insn_valid,
   input wire logic [15:0] insn,
   output logic insn_ready,
   output logic [31:0] program_counter,
   output logic [31:0] status_word,
   output logic cond_flag,
   input wire logic [31:0] global_base,
   input wire logic [31:0] vector_base,
   output logic mem_req,
   output logic mem_we,
   output logic mem_byte,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic gpr_ext_we,
   input wire logic [3:0] gpr_ext_sel,
   input wire logic [31:0] gpr_ext_data,
   input wire logic [3:0] dbg_sel,
   output logic [31:0] dbg_gpr,
   output logic [31:0] wrap_bounds,
   output logic [31:0] loop_finish_addr,
   output logic [31:0] loop_begin_addr,
   output logic [31:0] dsp_flags_word,
   output logic [31:0] accum_zero,
   output logic [31:0] in_x_first,
   output logic [31:0] in_x_second,
   output logic [31:0] in_y_first,
   output logic [31:0] in_y_second
);
   // Opcode compare under a mask
   function automatic logic hit(input logic [15:0] op, input logic [15:0] mask, input logic [15:0] val);
      return (op & mask) == val;
   endfunction

   // DSP target code for the register or post-increment form
   function automatic logic [3:0] dsp_dst(input logic [15:0] op, input logic mem);
      logic [3:0] d;
      d = DST_NONE;
      for (int i = 0; i < CTL_N; i++)
      begin
         if (op[15:12] == OP_GRP4 && op[7:0] == (mem ? MEM_LOW[i] : REG_LOW[i]))
            d = 4'(i + 1);
      end
      return d;
   endfunction

   // General register count; index 15 doubles as stack pointer
   localparam int GPR_N = 16;
   logic [31:0] gpr_reg [GPR_N];
   logic [31:0] ctl_reg [CTL_N];
   logic [31:0] pc_reg, sr_reg, dbg_reg;
   logic [31:0] mem_addr_reg, mem_wdata_reg;
   logic mem_req_reg, mem_we_reg, mem_byte_reg, pend_reg, ready_reg;
   logic [3:0] tag_req_reg, tag_pend_reg, cnt_reg;
   logic [7:0] hold_imm_reg;
   ids_state_t st_reg, st_next;

   // Operand fields
   wire logic fire = insn_valid & ready_reg;
   wire logic [7:0] imm = insn[7:0];
   wire logic [31:0] ra = gpr_reg[insn[11:8]];
   wire logic [31:0] rb = gpr_reg[insn[7:4]];
   wire logic [31:0] rz = gpr_reg[IDX_ZERO];
   wire logic [31:0] sp = gpr_reg[SP_IDX];
   wire logic [7:0] rd_byte = mem_rdata[7:0];

   // Register-to-register decode
   wire logic is_swapb = hit(insn, MASK_NM, OP_SWAPB);
   wire logic is_swapw = hit(insn, MASK_NM, OP_SWAPW);
   wire logic is_andt = hit(insn, MASK_NM, OP_AND_T);
   wire logic is_xor = hit(insn, MASK_NM, OP_XOR);
   wire logic is_midx = hit(insn, MASK_NM, OP_MIDX);

   // Single-register decode
   wire logic is_tset = hit(insn, MASK_N, OP_TSET);
   wire logic is_setr = hit(insn, MASK_N, OP_SETR);

   // Immediate and displacement decode
   wire logic is_trap = hit(insn, MASK_HI, OP_TRAP);
   wire logic is_andi = hit(insn, MASK_HI, OP_ANDI_T);
   wire logic is_andb = hit(insn, MASK_HI, OP_ANDB_T);
   wire logic is_xori = hit(insn, MASK_HI, OP_XORI);
   wire logic is_xorb = hit(insn, MASK_HI, OP_XORB);
   wire logic is_fin_rel = hit(insn, MASK_HI, OP_FIN_REL);
   wire logic is_beg_rel = hit(insn, MASK_HI, OP_BEG_REL);
   wire logic is_seti = hit(insn, MASK_HI, OP_SETI);

   // DSP load targets; only wrap, finish and begin memory forms are slow
   wire logic [3:0] rdst = dsp_dst(insn, 1'b0);
   wire logic [3:0] mdst = dsp_dst(insn, 1'b1);
   wire logic slow_ld = (mdst == DST_WRAP) | (mdst == DST_FIN) | (mdst == DST_BEG);

   // Execution length of the accepted instruction
   wire logic [3:0] ncyc = is_tset ? CYC_TSET :
      is_trap ? CYC_TRAP :
      is_andb ? CYC_ANDB :
      is_xorb ? CYC_XORB :
      slow_ld ? CYC_LDCL : CYC_ONE;

   // Trap steps: status push, counter push, then vector read
   wire logic trap_pc = (st_reg == ST_TRAP) && (cnt_reg == TRAP_STEP_PC);
   wire logic trap_vec = (st_reg == ST_TRAP) && (cnt_reg == TRAP_STEP_VEC);

   // Remaining busy cycles; loaded on accept, counts down to zero
   wire logic [3:0] cnt_next = fire ? ncyc - CYC_ONE : (cnt_reg != 4'h0) ? cnt_reg - CYC_ONE : 4'h0;

   // Next sequencer state
   always_comb
   begin
      unique case (st_reg)
         ST_IDLE: st_next = !fire || ncyc == CYC_ONE ? ST_IDLE : is_trap ? ST_TRAP : ST_STALL;
         ST_STALL: st_next = cnt_next == 4'h0 ? ST_IDLE : ST_STALL;
         ST_TRAP: st_next = cnt_next == 4'h0 ? ST_IDLE : ST_TRAP;
         default: st_next = ST_IDLE;
      endcase
   end

   // Register file write: swaps, XOR, extract, post-increment, stack push
   wire logic [31:0] alu_val = is_swapb ? {rb[31:16], rb[7:0], rb[15:8]} :
      is_swapw ? {rb[15:0], rb[31:16]} :
      is_xor ? ra ^ rb :
      {rb[15:0], ra[31:16]};

   // Write enables by source; only one source is live per cycle
   wire logic g_alu = fire & (is_swapb | is_swapw | is_xor | is_midx);
   wire logic g_inc = fire & (mdst != DST_NONE);
   wire logic g_push = (fire & is_trap) | trap_pc;
   wire logic g_xori = fire & is_xori;
   wire logic gw_en = g_alu | g_inc | g_push | g_xori;

   // Port select and value; the stack push wins over the rest
   wire logic [3:0] gw_sel = g_push ? SP_IDX : g_xori ? IDX_ZERO : insn[11:8];
   wire logic [31:0] gw_val = g_push ? sp - WORD_STEP :
      g_inc ? ra + WORD_STEP :
      g_xori ? rz ^ {24'h0, imm} :
      alu_val;

   // Memory request sources
   wire logic rq_tset = fire & is_tset;
   wire logic rq_gb = fire & (is_andb | is_xorb);
   wire logic rq_wb = pend_reg & ((tag_pend_reg == DST_TSET) | (tag_pend_reg == DST_XORB));
   wire logic rq_en = g_inc | rq_tset | rq_gb | g_push | trap_vec | rq_wb;

   // Write-back byte of the read-modify-write forms
   wire logic [7:0] wb_byte = (tag_pend_reg == DST_TSET) ? rd_byte | TSET_MSB : rd_byte ^ hold_imm_reg;

   // Address and data of the next request
   wire logic [31:0] rq_addr = g_push ? sp - WORD_STEP :
      trap_vec ? vector_base + {22'h0, hold_imm_reg, 2'b00} :
      rq_gb ? rz + global_base :
      rq_wb ? mem_addr_reg : ra;
   wire logic [31:0] rq_data = rq_wb ? {24'h0, wb_byte} : fire ? sr_reg : pc_reg;

   // Tag travels with the request so returning data finds its target
   wire logic [3:0] rq_tag = g_inc ? mdst : rq_tset ? DST_TSET :
      rq_gb ? (is_andb ? DST_ANDB : DST_XORB) : trap_vec ? DST_VEC : DST_NONE;

   // Relative address: instruction address plus four plus twice the displacement
   wire logic [31:0] pc_rel = pc_reg + PC_READ_OFS + {{23{imm[7]}}, imm, 1'b0};

   // Control register writes: accepted instruction and returning load data
   wire logic [3:0] cf_sel = rdst != DST_NONE ? rdst : is_fin_rel ? DST_FIN : is_beg_rel ? DST_BEG : DST_NONE;
   wire logic [31:0] cf_val = rdst != DST_NONE ? ra : pc_rel;
   wire logic [3:0] cp_sel = pend_reg ? tag_pend_reg : DST_NONE;

   // Test results; each writes the flag true or false
   wire logic t_andi = (rz[7:0] & imm) == BYTE_ZERO;
   wire logic t_andt = (ra & rb) == 32'h0;
   wire logic t_tset = rd_byte == BYTE_ZERO;
   wire logic t_andb = (rd_byte & hold_imm_reg) == BYTE_ZERO;

   // Status word next value
   logic [31:0] sr_next;
   always_comb
   begin
      sr_next = sr_reg;
      // Flag writers; at most one is live in a cycle
      if (fire & is_andi)
         sr_next[SR_T] = t_andi;
      if (fire & is_andt)
         sr_next[SR_T] = t_andt;
      if (pend_reg && tag_pend_reg == DST_TSET)
         sr_next[SR_T] = t_tset;
      if (pend_reg && tag_pend_reg == DST_ANDB)
         sr_next[SR_T] = t_andb;
      // Loop count field, register or immediate form
      if (fire & is_setr)
         sr_next[CNT_HI:CNT_LO] = ra[11:0];
      if (fire & is_seti)
      begin
         sr_next[CNT_IMM_HI:CNT_LO] = imm;
         sr_next[CNT_HI:CNT_TOP_LO] = 4'h0;
      end
   end

   // Program counter: step on issue, vector fetch on trap
   wire logic [31:0] pc_next = (pend_reg && tag_pend_reg == DST_VEC) ? mem_rdata :
      fire ? pc_reg + PC_STEP : pc_reg;

   // Sequencer, status and counter
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         ready_reg <= 1'b1;
         pc_reg <= PC_RESET;
         sr_reg <= SR_RESET;
         hold_imm_reg <= 8'h00;
      end
      else
      begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         ready_reg <= st_next == ST_IDLE;
         pc_reg <= pc_next;
         sr_reg <= sr_next;
         hold_imm_reg <= fire ? imm : hold_imm_reg;
      end
   end

   // Memory request flops, one-cycle request
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_byte_reg <= 1'b0;
         mem_addr_reg <= 32'h0;
         mem_wdata_reg <= 32'h0;
         tag_req_reg <= DST_NONE;
         pend_reg <= 1'b0;
         tag_pend_reg <= DST_NONE;
      end
      else
      begin
         mem_req_reg <= rq_en;
         mem_we_reg <= rq_en & (g_push | rq_wb);
         mem_byte_reg <= rq_en & (rq_tset | rq_gb | rq_wb);
         mem_addr_reg <= rq_en ? rq_addr : mem_addr_reg;
         mem_wdata_reg <= rq_en ? rq_data : mem_wdata_reg;
         tag_req_reg <= rq_tag;
         pend_reg <= mem_req_reg & ~mem_we_reg;
         tag_pend_reg <= tag_req_reg;
      end
   end

   // General registers; internal write beats the external port
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < GPR_N; i++)
            gpr_reg[i] <= 32'h0;
         dbg_reg <= 32'h0;
      end
      else
      begin
         if (gw_en)
            gpr_reg[gw_sel] <= gw_val;
         else if (gpr_ext_we)
            gpr_reg[gpr_ext_sel] <= gpr_ext_data;
         dbg_reg <= gpr_reg[dbg_sel];
      end
   end

   // DSP and loop registers; the later instruction wins a same-cycle clash
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < CTL_N; i++)
            ctl_reg[i] <= 32'h0;
      end
      else
      begin
         for (int i = 0; i < CTL_N; i++)
         begin
            if (fire && cf_sel == 4'(i + 1))
               ctl_reg[i] <= cf_val;
            else if (cp_sel == 4'(i + 1))
               ctl_reg[i] <= mem_rdata;
         end
      end
   end

   // Outputs straight from flops
   // Instruction port and status
   assign insn_ready = ready_reg;
   assign program_counter = pc_reg;
   assign status_word = sr_reg;
   assign cond_flag = sr_reg[SR_T];

   // Data memory request
   assign mem_req = mem_req_reg;
   assign mem_we = mem_we_reg;
   assign mem_byte = mem_byte_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;

   // Debug read of the general registers
   assign dbg_gpr = dbg_reg;

   // Loop, modulo and DSP registers
   assign wrap_bounds = ctl_reg[0];
   assign loop_finish_addr = ctl_reg[1];
   assign loop_begin_addr = ctl_reg[2];
   assign dsp_flags_word = ctl_reg[3];
   assign accum_zero = ctl_reg[4];
   assign in_x_first = ctl_reg[5];
   assign in_x_second = ctl_reg[6];
   assign in_y_first = ctl_reg[7];
   assign in_y_second = ctl_reg[8];
endmodule // ids_core
`default_nettype wire

// file: sim/ids_mem_model.sv
// Data memory partner: byte array that answers one cycle after a request.
// Assumes the core issues requests on the shared rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ids_mem_model
(
   input wire logic clock,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_byte,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata
);
   logic [7:0] mem [256];
   logic [7:0] a;
   assign a = mem_addr[7:0];
   initial mem_rdata = 32'h0;
   // Store writes, answer reads next cycle, scramble the bus otherwise
   always @(posedge clock)
   begin
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_we)
      begin
         mem[a] <= mem_wdata[7:0];
         if (!mem_byte)
            {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1]} <= mem_wdata[31:8];
      end
      else if (mem_req)
         mem_rdata <= mem_byte ? {~mem_rdata[31:8], mem[a]} : {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]};
   end
endmodule // ids_mem_model
`default_nettype wire

// file: sim/ids_core_props.sv
// Port-level timing and data checks for the decoder.
// Assumes a memory that answers exactly one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module ids_core_props
   import ids_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic insn_valid,
   input wire logic [15:0] insn,
   input wire logic insn_ready,
   input wire logic [31:0] program_counter,
   input wire logic [31:0] status_word,
   input wire logic cond_flag,
   input wire logic [31:0] vector_base,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_byte,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic [31:0] wrap_bounds,
   input wire logic [31:0] loop_finish_addr
);
   logic acc;
   logic [7:0] imm;
   logic [7:0] rd_b;
   logic [31:0] dsp2;
   // Accept strobe and operand fields
   assign acc = insn_valid && insn_ready;
   assign imm = insn[7:0];
   assign rd_b = mem_rdata[7:0];
   assign dsp2 = {{23{insn[7]}}, insn[7:0], 1'b0};
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   a_tset_busy_time: assert property (acc && (insn & MASK_N) == OP_TSET |=> !insn_ready [*3] ##1 insn_ready)
      else $error("test-and-set busy time wrong");
   a_tset_write_flag: assert property (acc && (insn & MASK_N) == OP_TSET |=> ##2 mem_req && mem_we && mem_byte
      && mem_wdata[7:0] == ($past(rd_b) | 8'h80) && cond_flag == ($past(rd_b) == 8'h00))
      else $error("test-and-set write or flag wrong");
   a_trap_busy_time: assert property (acc && (insn & MASK_HI) == OP_TRAP |=> !insn_ready [*7] ##1 insn_ready)
      else $error("trap busy time wrong");
   a_trap_vector_load: assert property (acc && (insn & MASK_HI) == OP_TRAP |=> ##2 mem_req && !mem_we
      && mem_addr == vector_base + {22'h0, $past(imm, 3), 2'b00} ##2 program_counter == $past(mem_rdata))
      else $error("trap vector fetch wrong");
   a_mtest_busy_time: assert property (acc && (insn & MASK_HI) == OP_ANDB_T |=> !insn_ready [*2] ##1 insn_ready)
      else $error("memory test busy time wrong");
   a_mxor_write_back: assert property (acc && (insn & MASK_HI) == OP_XORB |=> mem_req && !mem_we && mem_byte
      ##2 mem_req && mem_we && mem_wdata[7:0] == ($past(rd_b) ^ $past(imm, 3)))
      else $error("memory xor write wrong");
   a_count_imm_set: assert property (acc && (insn & MASK_HI) == OP_SETI |=> status_word[27:16] == {4'h0, $past(imm)})
      else $error("immediate loop count wrong");
   a_finish_pc_rel: assert property (acc && (insn & MASK_HI) == OP_FIN_REL
      |=> loop_finish_addr == $past(program_counter) + 32'h4 + $past(dsp2))
      else $error("relative finish address wrong");
   a_wrap_mem_load: assert property (acc && (insn & MASK_N) == 16'h4057 |=> mem_req && !mem_we && !mem_byte
      && !insn_ready ##1 !insn_ready ##1 insn_ready && wrap_bounds == $past(mem_rdata))
      else $error("wrap bounds memory load wrong");
   // Main scenarios reached
   c_trap: cover property (acc && (insn & MASK_HI) == OP_TRAP);
   c_tset: cover property (acc && (insn & MASK_N) == OP_TSET);
   c_mxor: cover property (acc && (insn & MASK_HI) == OP_XORB);
endmodule // ids_core_props
bind ids_core ids_core_props u_props (.*);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the decoder with a memory partner model.
// Assumes registers are set and read through the external and debug ports.
`timescale 1ns/1ps
`default_nettype none
module tb
   import ids_pkg::*;
();
   logic clock, arst_n, insn_valid, insn_ready, cond_flag, gpr_ext_we, mem_req, mem_we, mem_byte;
   logic [15:0] insn;
   logic [3:0] gpr_ext_sel, dbg_sel;
   logic [31:0] program_counter, status_word, global_base, vector_base, mem_addr, mem_wdata, mem_rdata, v, w;
   logic [31:0] gpr_ext_data, dbg_gpr, wrap_bounds, loop_finish_addr, loop_begin_addr, dsp_flags_word;
   logic [31:0] accum_zero, in_x_first, in_x_second, in_y_first, in_y_second;
   int fail_count = 0;
   int cmp_count = 0;
   ids_core u_dut (.*);
   ids_mem_model u_mem (.*);
   // Free-running clock
   initial
   begin
      clock = 0;
      forever #2.5 clock = ~clock;
   end
   task automatic close_out();
      if (fail_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic idle();
      int k;
      for (k = 0; k < 20 && insn_ready !== 1'b1; k++)
         tick();
      if (k == 20)
      begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic issue(input logic [15:0] op);
      idle();
      insn = op;
      insn_valid = 1;
      tick();
      insn_valid = 0;
      idle();
      tick(2);
   endtask
   task automatic wr(input logic [3:0] r, input logic [31:0] d);
      gpr_ext_we = 1;
      gpr_ext_sel = r;
      gpr_ext_data = d;
      tick();
      gpr_ext_we = 0;
   endtask
   task automatic rd(input logic [3:0] r, input logic [31:0] exp);
      dbg_sel = r;
      tick(2);
      chk(dbg_gpr, exp);
   endtask
   task automatic mw(input logic [7:0] a, input logic [31:0] d);
      {u_mem.mem[a+8'h3], u_mem.mem[a+8'h2], u_mem.mem[a+8'h1], u_mem.mem[a]} = d;
   endtask
   function automatic logic [31:0] mword(input logic [7:0] a);
      return {u_mem.mem[a+8'h3], u_mem.mem[a+8'h2], u_mem.mem[a+8'h1], u_mem.mem[a]};
   endfunction
   function automatic logic [31:0] pick(input int k);
      case (k)
         0: return wrap_bounds;
         1: return loop_finish_addr;
         2: return loop_begin_addr;
         3: return dsp_flags_word;
         4: return accum_zero;
         5: return in_x_first;
         6: return in_x_second;
         7: return in_y_first;
         default: return in_y_second;
      endcase
   endfunction
   task automatic t_swap_extract();
      wr(1, 32'h11223344);
      wr(4, 32'haabbccdd);
      issue(16'h6218);
      rd(2, 32'h11224433);
      issue(16'h6319);
      rd(3, 32'h33441122);
      issue(16'h241d);
      rd(4, 32'h3344aabb);
   endtask
   task automatic t_flag_tests();
      wr(0, 32'hf0);
      wr(5, 32'h0f);
      issue(16'h2508);
      chk({31'h0, cond_flag}, 32'h1);
      rd(5, 32'h0f);
      issue(16'hc810);
      chk({31'h0, cond_flag}, 32'h0);
      issue(16'hc80f);
      chk({31'h0, cond_flag}, 32'h1);
      issue(16'hca0f);
      rd(0, 32'hff);
      issue(16'h250a);
      rd(5, 32'hf0);
      chk({31'h0, cond_flag}, 32'h1);
   endtask
   task automatic t_mem_bytes();
      global_base = 32'h40;
      wr(0, 32'h10);
      u_mem.mem[8'h50] = 8'h0f;
      issue(16'hcc30);
      chk({31'h0, cond_flag}, 32'h1);
      issue(16'hcc01);
      chk({31'h0, cond_flag}, 32'h0);
      issue(16'hce3c);
      chk({24'h0, u_mem.mem[8'h50]}, 32'h33);
      wr(5, 32'h60);
      u_mem.mem[8'h60] = 8'h00;
      issue(16'h451b);
      chk({23'h0, cond_flag, u_mem.mem[8'h60]}, 32'h180);
      issue(16'h451b);
      chk({23'h0, cond_flag, u_mem.mem[8'h60]}, 32'h080);
   endtask
   task automatic t_trap();
      wr(15, 32'h100);
      vector_base = 32'h80;
      mw(8'h8c, 32'h200);
      v = program_counter;
      w = status_word;
      issue(16'hc303);
      chk(program_counter, 32'h200);
      rd(15, 32'hf8);
      chk(mword(8'hfc), w);
      chk(mword(8'hf8), v + 32'h2);
   endtask
   task automatic t_dsp_loads();
      for (int k = 0; k < CTL_N; k++)
      begin
         wr(6, 32'h1000 + 32'(k));
         issue({8'h46, REG_LOW[k]});
         chk(pick(k), 32'h1000 + 32'(k));
         wr(7, 32'h20);
         mw(8'h20, 32'ha0000000 + 32'(k));
         issue({8'h47, MEM_LOW[k]});
         chk(pick(k), 32'ha0000000 + 32'(k));
         rd(7, 32'h24);
      end
   endtask
   task automatic t_rel_count();
      v = program_counter;
      issue(16'h8efe);
      chk(loop_finish_addr, v);
      v = program_counter;
      issue(16'h8c10);
      chk(loop_begin_addr, v + 32'h24);
      wr(8, 32'hfffff5a5);
      issue(16'h4814);
      chk({20'h0, status_word[27:16]}, 32'h5a5);
      issue(16'h82c3);
      chk({20'h0, status_word[27:16]}, 32'h0c3);
   endtask
   // Reset, then run every scenario
   initial
   begin
      arst_n = 0;
      insn_valid = 0;
      insn = 16'h0;
      gpr_ext_we = 0;
      gpr_ext_sel = 4'h0;
      gpr_ext_data = 32'h0;
      dbg_sel = 4'h0;
      global_base = 32'h0;
      vector_base = 32'h0;
      tick(10);
      arst_n = 1;
      tick();
      t_swap_extract();
      t_flag_tests();
      t_mem_bytes();
      t_trap();
      t_dsp_loads();
      t_rel_count();
      close_out();
   end
endmodule // tb
`default_nettype wire
